// ===== design/ccc_pkg.sv
/*
 Constants for the charge cycle control block: register offsets, field
 positions, reset values, timing constants.
 Assumes a 125 MHz core clock and a 32-bit APB register bus.
*/
package ccc_pkg;
  localparam int CLK_KHZ = 125000;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FAST_CHARGE_CURRENT = 8'h04;
  localparam logic [7:0] OFF_TERM = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  // Control register fields
  localparam int F_CHG_EN = 0;
  localparam int F_THERM_IGN = 1;
  localparam int F_SW_OFF = 2;
  localparam int F_TERM_EN = 3;
  localparam int F_RECHG_SEL = 4;
  localparam int F_SNS_DIS = 5;
  localparam int F_TOPOFF_LO = 6;
  localparam int CTRL_W = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h09;
  localparam int FAST_CHARGE_CURRENT_W = 6;
  localparam logic [FAST_CHARGE_CURRENT_W-1:0] FAST_CHARGE_CURRENT_RST = 6'h11;
  localparam int TERM_W = 4;
  localparam logic [TERM_W-1:0] TERM_RST = 4'h2;
  // Status register fields
  localparam int S_MINSYS = 0;
  localparam int S_VLIM = 1;
  localparam int S_ILIM = 2;
  localparam int S_PHASE_LO = 3;
  localparam int S_TOPOFF = 5;
  localparam int S_SWITCH = 6;
  localparam int S_FAULT = 7;
  localparam logic [1:0] PH_OFF = 2'h0;
  localparam logic [1:0] PH_PRE = 2'h1;
  localparam logic [1:0] PH_FAST = 2'h2;
  localparam logic [1:0] PH_DONE = 2'h3;
  localparam logic [1:0] CUR_NONE = 2'h0;
  localparam logic [1:0] CUR_SHORT = 2'h1;
  localparam logic [1:0] CUR_PRE = 2'h2;
  localparam logic [1:0] CUR_FAST = 2'h3;
  // Timer tick and status blink half period, in milliseconds
  localparam int TICK_MS = 1000;
  localparam int BLINK_HALF_MS = 500;
  localparam int TICK_CYC = TICK_MS * CLK_KHZ;
  localparam int BLINK_CYC = BLINK_HALF_MS * CLK_KHZ;
  localparam int TOPOFF_UNIT_TICKS = 900;
  localparam int ALERT_CYC = 8;
  typedef enum logic [2:0] {
    CC_OFF, CC_SHORT, CC_PRE, CC_FAST, CC_TOPOFF, CC_DONE
  } ccc_state_t;
endpackage

// ===== design/ccc_top.sv
/*
 Charge cycle control: cycle start, phase selection, termination,
 recharge, top-off timer, status pin, host alert pulses, APB registers.
 Assumes analog comparators and the safety timer deliver level inputs
 from outside this clock domain; APB master on mclk_i.
*/
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/10ps
// Functional notes
// - Minimum-system flag is 1 while system sits at minimum system voltage.
// - Input overcurrent or undervoltage reduces charge current until both limits hold.
// - During power limiting, the flag of the limit in control reads 1.
// - Battery switch on when system drops below battery; off below depletion.
// - Charging enabled only with enable bit 1 and enable pin low.
// - New cycle needs converter, enable, nonzero current, no faults, switch-off bit 0.
// - Terminate on low current, battery above recharge, no limiting or thermal loop.
// - After done, battery below recharge threshold starts a new cycle.
// - After done, toggling enable or replugging the adapter restarts charging.
// - Status pin low charging, high done or disabled, blinking on fault.
// - Phase field: 00 off, 01 precharge, 10 fast, 11 done.
// - Termination sets phase done, status pin high, one alert pulse.
// - After done, battery switch off and converter keeps feeding the system.
// - Remote sensing by default; disable bit or grounded sense input turns it off.
// - Termination threshold comes from the low four bits of the termination register.
// - Top-off timer pauses and halves its rate with the safety timer.
// - Top-off running keeps status pin high and sets the top-off flag.
// - Top-off setting sampled at termination; writing zero stops it at once.
// - Alert pulse on entering top-off and again on its expiry.
module ccc_top
  import ccc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int BLINK_CYCLES = BLINK_CYC,
  parameter int TOPOFF_UNIT = TOPOFF_UNIT_TICKS
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic conv_run_i,
  input wire logic chg_en_n_i,
  input wire logic src_good_i,
  input wire logic therm_fault_i,
  input wire logic safety_fault_i,
  input wire logic safety_pause_i,
  input wire logic safety_half_i,
  input wire logic sys_at_min_i,
  input wire logic iin_over_i,
  input wire logic vin_under_i,
  input wire logic sys_below_bat_i,
  input wire logic bat_depleted_i,
  input wire logic bat_below_2v2_i,
  input wire logic bat_below_3v_i,
  input wire logic fast_charge_current_below_term_i,
  input wire logic bat_above_rechg_i,
  input wire logic thermal_reg_i,
  input wire logic sense_grounded_i,
  output logic stat_o,
  output logic alert_n_o,
  output logic bat_switch_on_o,
  output logic chg_reduce_o,
  output logic [1:0] chg_current_sel_o,
  output logic [TERM_W-1:0] term_thresh_o,
  output logic rechg_sel_o,
  output logic remote_sense_en_o
);
  localparam int NSYNC = 18;
  logic [NSYNC-1:0] raw, sync1, sync2;
  logic conv_run, chg_en_n, src_good, therm_fault, safety_fault, safety_pause;
  logic safety_half, sys_at_min, iin_over, vin_under, sys_below_bat;
  logic bat_depleted, bat_short, bat_low, fast_charge_current_low, bat_full, thermal_reg;
  logic sense_gnd;
  assign raw = {conv_run_i, chg_en_n_i, src_good_i, therm_fault_i, safety_fault_i,
    safety_pause_i, safety_half_i, sys_at_min_i, iin_over_i, vin_under_i,
    sys_below_bat_i, bat_depleted_i, bat_below_2v2_i, bat_below_3v_i,
    fast_charge_current_below_term_i, bat_above_rechg_i, thermal_reg_i, sense_grounded_i};
  assign {conv_run, chg_en_n, src_good, therm_fault, safety_fault, safety_pause,
    safety_half, sys_at_min, iin_over, vin_under, sys_below_bat, bat_depleted,
    bat_short, bat_low, fast_charge_current_low, bat_full, thermal_reg, sense_gnd} = sync2;

  // Two-flop synchronisers, one per pin
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end else begin
          sync1[gi] <= raw[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  // Registers and APB slave; answers two cycles after setup
  logic [CTRL_W-1:0] ctrl;
  logic [FAST_CHARGE_CURRENT_W-1:0] fast_charge_current;
  logic [TERM_W-1:0] term_reg;
  logic [7:0] status;
  logic wr_go, rd_go, hit;
  assign hit = (paddr_i == OFF_CTRL) || (paddr_i == OFF_FAST_CHARGE_CURRENT) ||
               (paddr_i == OFF_TERM) || (paddr_i == OFF_STAT);
  assign wr_go = psel_i && penable_i && pready_o && pwrite_i;
  assign rd_go = psel_i && penable_i && !pready_o && !pwrite_i;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !hit;
      if (rd_go) begin
        case (paddr_i)
          OFF_CTRL: prdata_o <= {24'h0, ctrl};
          OFF_FAST_CHARGE_CURRENT: prdata_o <= {26'h0, fast_charge_current};
          OFF_TERM: prdata_o <= {28'h0, term_reg};
          OFF_STAT: prdata_o <= {24'h0, status};
          default: prdata_o <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RST;
      fast_charge_current <= FAST_CHARGE_CURRENT_RST;
      term_reg <= TERM_RST;
    end else if (wr_go) begin
      if (paddr_i == OFF_CTRL) ctrl <= pwdata_i[CTRL_W-1:0];
      if (paddr_i == OFF_FAST_CHARGE_CURRENT) fast_charge_current <= pwdata_i[FAST_CHARGE_CURRENT_W-1:0];
      if (paddr_i == OFF_TERM) term_reg <= pwdata_i[TERM_W-1:0];
    end
  end

  logic [1:0] topoff_set;
  logic chg_enabled, can_start, fault, limiting, term_hit;
  assign topoff_set = ctrl[F_TOPOFF_LO+1:F_TOPOFF_LO];
  assign chg_enabled = ctrl[F_CHG_EN] && !chg_en_n;
  assign fault = safety_fault || (therm_fault && !ctrl[F_THERM_IGN]);
  assign can_start = conv_run && src_good && chg_enabled && (fast_charge_current != '0) &&
                     !fault && !ctrl[F_SW_OFF];
  assign limiting = iin_over || vin_under;
  // Termination enable is read live here, so clearing it before termination blocks it
  assign term_hit = fast_charge_current_low && bat_full && !limiting && !thermal_reg &&
                    ctrl[F_TERM_EN];

  // Timer tick and blink dividers
  logic [31:0] tick_cnt, blink_cnt;
  logic tick, blink, half_skip;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
      blink_cnt <= 32'h0;
      blink <= 1'b0;
    end else begin
      tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt + 32'h1;
      blink_cnt <= (blink_cnt == 32'(BLINK_CYCLES - 1)) ? 32'h0 : blink_cnt + 32'h1;
      if (blink_cnt == 32'(BLINK_CYCLES - 1)) blink <= !blink;
    end
  end

  // Charge cycle state machine
  ccc_state_t state, next_state;
  logic [1:0] topoff_latched;
  logic [31:0] topoff_cnt;
  logic topoff_expire, ev_term, ev_topoff_in;
  assign topoff_expire = (topoff_cnt == 32'(TOPOFF_UNIT) * 32'(topoff_latched));

  always_comb begin
    next_state = state;
    case (state)
      CC_OFF: begin
        if (can_start) begin
          if (bat_short) next_state = CC_SHORT;
          else if (bat_low) next_state = CC_PRE;
          else next_state = CC_FAST;
        end
      end
      CC_SHORT, CC_PRE, CC_FAST: begin
        if (!can_start) next_state = CC_OFF;
        else if (state == CC_SHORT && !bat_short) next_state = CC_PRE;
        else if (state == CC_PRE && !bat_low) next_state = CC_FAST;
        else if (state == CC_FAST && term_hit) begin
          next_state = (topoff_set != 2'h0) ? CC_TOPOFF : CC_DONE;
        end
      end
      CC_TOPOFF: begin
        if (!can_start) next_state = CC_OFF;
        else if (topoff_set == 2'h0 || topoff_expire) next_state = CC_DONE;
      end
      CC_DONE: begin
        // Enable toggle or adapter loss drops to off, off restarts later
        if (!can_start) next_state = CC_OFF;
        else if (!bat_full) next_state = CC_OFF;
      end
      default: next_state = CC_OFF;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) state <= CC_OFF;
    else state <= next_state;
  end

  // Only a real termination counts; losing a start condition is not one
  assign ev_term = (state == CC_FAST) && (next_state == CC_TOPOFF || next_state == CC_DONE);
  assign ev_topoff_in = ev_term && (next_state == CC_TOPOFF);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      topoff_latched <= 2'h0;
      topoff_cnt <= 32'h0;
      half_skip <= 1'b0;
    end else if (ev_term) begin
      topoff_latched <= topoff_set;
      topoff_cnt <= 32'h0;
      half_skip <= 1'b0;
    end else if (state == CC_TOPOFF && tick && !safety_pause) begin
      half_skip <= safety_half && !half_skip;
      if (!(safety_half && half_skip)) topoff_cnt <= topoff_cnt + 32'h1;
    end
  end

  // Alert pulses: up to three pending events queue up so none is merged; further ones are dropped
  logic [1:0] alert_pend;
  logic [3:0] alert_cnt;
  logic alert_busy;
  logic [1:0] ev_count;
  logic ev_topoff_out;
  logic [2:0] pend_sum;
  assign ev_topoff_out = (state == CC_TOPOFF) && topoff_expire && next_state == CC_DONE;
  assign ev_count = {1'b0, ev_term} + {1'b0, ev_topoff_in} + {1'b0, ev_topoff_out};
  // Wide enough that a burst of events cannot wrap the queue count
  assign pend_sum = {1'b0, alert_pend} + {1'b0, ev_count};

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      alert_pend <= 2'h0;
      alert_cnt <= 4'h0;
      alert_busy <= 1'b0;
      alert_n_o <= 1'b1;
    end else begin
      if (!alert_busy && alert_pend != 2'h0) begin
        alert_busy <= 1'b1;
        alert_cnt <= 4'h0;
        alert_n_o <= 1'b0;
        alert_pend <= (pend_sum > 3'h4) ? 2'h3 : 2'(pend_sum - 3'h1);
      end else begin
        alert_pend <= (pend_sum > 3'h3) ? 2'h3 : pend_sum[1:0];
        if (alert_busy) begin
          alert_cnt <= alert_cnt + 4'h1;
          // Low for ALERT_CYC, then high for ALERT_CYC + 1 cycles before the next
          if (alert_cnt == 4'(ALERT_CYC - 1)) alert_n_o <= 1'b1;
          if (alert_cnt == 4'(2 * ALERT_CYC - 1)) alert_busy <= 1'b0;
        end
      end
    end
  end

  // Power path: supplement latch and battery switch
  logic supplement;
  logic charging;
  assign charging = (state == CC_SHORT) || (state == CC_PRE) || (state == CC_FAST) ||
                    (state == CC_TOPOFF);
  always_ff @(posedge mclk_i) begin
    if (rst_i) supplement <= 1'b0;
    else if (bat_depleted) supplement <= 1'b0;
    else if (sys_below_bat) supplement <= 1'b1;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bat_switch_on_o <= 1'b0;
      chg_reduce_o <= 1'b0;
      chg_current_sel_o <= CUR_NONE;
      term_thresh_o <= TERM_RST;
      rechg_sel_o <= 1'b0;
      remote_sense_en_o <= 1'b0;
      stat_o <= 1'b1;
    end else begin
      // Done state keeps it off unless supplement asks for it
      bat_switch_on_o <= !ctrl[F_SW_OFF] && (charging ||
                         (supplement && !bat_depleted));
      chg_reduce_o <= limiting;
      case (state)
        CC_SHORT: chg_current_sel_o <= CUR_SHORT;
        CC_PRE: chg_current_sel_o <= CUR_PRE;
        CC_FAST: chg_current_sel_o <= CUR_FAST;
        default: chg_current_sel_o <= CUR_NONE;
      endcase
      term_thresh_o <= term_reg;
      rechg_sel_o <= ctrl[F_RECHG_SEL];
      remote_sense_en_o <= !ctrl[F_SNS_DIS] && !sense_gnd;
      if (chg_enabled && fault) stat_o <= blink;
      else stat_o <= !(state == CC_SHORT || state == CC_PRE ||
                       state == CC_FAST);
    end
  end

  // Status register
  logic [1:0] phase;
  always_comb begin
    case (state)
      CC_SHORT, CC_PRE: phase = PH_PRE;
      CC_FAST: phase = PH_FAST;
      CC_TOPOFF, CC_DONE: phase = PH_DONE;
      default: phase = PH_OFF;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) status <= 8'h0;
    else begin
      status[S_MINSYS] <= sys_at_min;
      status[S_VLIM] <= vin_under;
      status[S_ILIM] <= iin_over;
      status[S_PHASE_LO+1:S_PHASE_LO] <= phase;
      status[S_TOPOFF] <= (state == CC_TOPOFF);
      status[S_SWITCH] <= bat_switch_on_o;
      status[S_FAULT] <= fault;
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  start_gate_a: assert property ((state == CC_OFF && next_state != CC_OFF) |->
    (chg_enabled && fast_charge_current != '0 && !ctrl[F_SW_OFF])) else $error("start without enable");
  phase_pick_a: assert property ((state == CC_OFF && can_start && bat_short) |=>
    state == CC_SHORT) else $error("short phase not chosen");
  term_cond_a: assert property (ev_term |-> (!limiting && !thermal_reg && bat_full))
    else $error("termination while limiting");
  done_phase_a: assert property ((state == CC_DONE) |=>
    status[S_PHASE_LO+1:S_PHASE_LO] == PH_DONE) else $error("done phase wrong");
  stat_low_a: assert property ((state == CC_FAST && !fault) |=> !stat_o)
    else $error("status pin not low while charging");
  topoff_stop_a: assert property ((state == CC_TOPOFF && topoff_set == 2'h0) |=>
    state != CC_TOPOFF) else $error("top-off not stopped");
  topoff_pin_a: assert property ((state == CC_TOPOFF && !fault) |=> ##1
    (stat_o || state != CC_TOPOFF)) else $error("status pin low in top-off");
  alert_len_a: assert property ($fell(alert_n_o) |-> !alert_n_o [*8] ##1
    alert_n_o [*8]) else $error("alert pulse length wrong");
  term_alert_a: assert property (ev_term |-> ##[1:40] !alert_n_o)
    else $error("no alert after termination");
  reduce_a: assert property ((iin_over || vin_under) |=> chg_reduce_o)
    else $error("charge current not reduced");
  done_switch_a: assert property ((state == CC_DONE && !supplement) |=>
    !bat_switch_on_o) else $error("switch on after done");
endmodule // ccc_top

// ===== tb/ccc_host_model.sv
/*
 Host side of the alert line: counts low pulses and checks their length
 and the high gap before each one.
 Assumes alert_n_i comes straight from the charge control block.
*/
`timescale 1ns/10ps
module ccc_host_model
  import ccc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic alert_n_i,
  output int pulses_o,
  output int bad_o
);
  int low_len;
  int high_len;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      low_len <= 0;
      high_len <= ALERT_CYC;
      pulses_o <= 0;
      bad_o <= 0;
    end else if (alert_n_i === 1'b0) begin
      low_len <= low_len + 1;
      high_len <= 0;
      if (low_len == 0 && high_len < ALERT_CYC) bad_o <= bad_o + 1;
    end else begin
      high_len <= high_len + 1;
      low_len <= 0;
      if (low_len != 0) begin
        pulses_o <= pulses_o + 1;
        if (low_len != ALERT_CYC) bad_o <= bad_o + 1;
      end
    end
  end
endmodule // ccc_host_model

// ===== tb/tb.sv
/*
 Bench for charge cycle control: APB tasks and pin sequences with
 expected values. Assumes shortened tick, blink and top-off parameters.
*/
`timescale 1ns/10ps
module tb
  import ccc_pkg::*;
;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, d;
  logic conv_run_i, chg_en_n_i, src_good_i, therm_fault_i, safety_fault_i, safety_pause_i;
  logic safety_half_i, sys_at_min_i, iin_over_i, vin_under_i, sys_below_bat_i, bat_depleted_i;
  logic bat_below_2v2_i, bat_below_3v_i, fast_charge_current_below_term_i, bat_above_rechg_i, thermal_reg_i;
  logic sense_grounded_i, stat_o, alert_n_o, bat_switch_on_o, chg_reduce_o, rechg_sel_o;
  logic remote_sense_en_o;
  logic [1:0] chg_current_sel_o;
  logic [TERM_W-1:0] term_thresh_o;
  int n_mismatch = 0;
  int checked = 0;
  int pulses, bad, p0, k, hi;

  ccc_top #(.TICK_CYCLES(8), .BLINK_CYCLES(6), .TOPOFF_UNIT(4)) i_ccc_top (
    .mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .conv_run_i, .chg_en_n_i, .src_good_i, .therm_fault_i,
    .safety_fault_i, .safety_pause_i, .safety_half_i, .sys_at_min_i, .iin_over_i,
    .vin_under_i, .sys_below_bat_i, .bat_depleted_i, .bat_below_2v2_i, .bat_below_3v_i,
    .fast_charge_current_below_term_i, .bat_above_rechg_i, .thermal_reg_i, .sense_grounded_i, .stat_o,
    .alert_n_o, .bat_switch_on_o, .chg_reduce_o, .chg_current_sel_o, .term_thresh_o,
    .rechg_sel_o, .remote_sense_en_o);
  ccc_host_model i_ccc_host_model (.mclk_i, .rst_i, .alert_n_i(alert_n_o), .pulses_o(pulses),
    .bad_o(bad));

  always #4 mclk_i = ~mclk_i;

  task automatic wn(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic chb(input logic s, input logic x);
    chk({31'h0, s}, {31'h0, x});
  endtask
  // Ready, data and error are taken at the rising edge that sees ready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
    end while (pready_o !== 1'b1);
    d = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic ph_chk(input logic [1:0] ph, input logic top);
    apb(1'b0, OFF_STAT, 32'h0);
    chk({29'h0, d[S_TOPOFF:S_PHASE_LO]}, {29'h0, top, ph});
  endtask
  task automatic restart();
    @(posedge mclk_i);
    fast_charge_current_below_term_i <= 1'b0;
    chg_en_n_i <= 1'b1;
    wn(8);
    @(posedge mclk_i);
    chg_en_n_i <= 1'b0;
    wn(8);
  endtask
  task automatic term(input int n);
    @(posedge mclk_i);
    fast_charge_current_below_term_i <= 1'b1;
    wn(n);
  endtask
  task automatic finish_test();
    $display("Counts: %0d compares, %0d mismatches", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #160000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {conv_run_i, src_good_i, therm_fault_i, safety_fault_i, safety_pause_i, safety_half_i} = '0;
    {sys_at_min_i, iin_over_i, vin_under_i, sys_below_bat_i, bat_depleted_i} = '0;
    {bat_below_2v2_i, bat_below_3v_i, fast_charge_current_below_term_i, bat_above_rechg_i} = '0;
    {thermal_reg_i, sense_grounded_i} = '0;
    chg_en_n_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    wn(4);
    chb(stat_o, 1'b1);
    chb(alert_n_o, 1'b1);
    chb(remote_sense_en_o, 1'b1);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(d, {24'h0, CTRL_RST});
    apb(1'b0, OFF_FAST_CHARGE_CURRENT, 32'h0);
    chk(d, {26'h0, FAST_CHARGE_CURRENT_RST});
    apb(1'b0, OFF_STAT, 32'h0);
    chk(d, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({d[30:0], e}, 32'h1);
    apb(1'b1, OFF_TERM, 32'hf5);
    apb(1'b0, OFF_TERM, 32'h0);
    chk(d, 32'h5);
    chk({28'h0, term_thresh_o}, 32'h5);
    apb(1'b1, OFF_CTRL, 32'h39);
    wn(2);
    chb(remote_sense_en_o, 1'b0);
    chb(rechg_sel_o, 1'b1);
    apb(1'b1, OFF_CTRL, 32'h09);
    sense_grounded_i <= 1'b1;
    wn(6);
    chb(remote_sense_en_o, 1'b0);
    $display("Test registers done");
    for (k = 0; k < 3; k++) begin
      @(posedge mclk_i);
      {iin_over_i, vin_under_i, sys_at_min_i} <= 3'h1 << k;
      wn(6);
      apb(1'b0, OFF_STAT, 32'h0);
      chk({29'h0, d[2:0]}, {29'h0, 3'h1 << k});
      chb(chg_reduce_o, k > 0);
    end
    {iin_over_i, vin_under_i, sys_at_min_i, sys_below_bat_i} <= 4'h1;
    wn(6);
    chb(bat_switch_on_o, 1'b1);
    apb(1'b0, OFF_STAT, 32'h0);
    chb(d[S_SWITCH], 1'b1);
    @(posedge mclk_i);
    sys_below_bat_i <= 1'b0;
    bat_depleted_i <= 1'b1;
    wn(6);
    chb(bat_switch_on_o, 1'b0);
    $display("Test power path done");
    @(posedge mclk_i);
    {bat_depleted_i, sense_grounded_i, conv_run_i, src_good_i} <= 4'h3;
    {bat_below_2v2_i, bat_below_3v_i} <= 2'h3;
    for (k = 0; k < 7; k++) begin
      @(posedge mclk_i);
      therm_fault_i <= (k == 0 || k == 6);
      safety_fault_i <= (k == 1);
      conv_run_i <= (k != 4);
      if (k == 2) apb(1'b1, OFF_CTRL, 32'h0d);
      if (k == 3) apb(1'b1, OFF_FAST_CHARGE_CURRENT, 32'h0);
      if (k == 5) apb(1'b1, OFF_CTRL, 32'h08);
      if (k == 6) apb(1'b1, OFF_CTRL, 32'h0b);
      restart();
      chk({30'h0, chg_current_sel_o}, (k == 6) ? 32'h1 : 32'h0);
      @(posedge mclk_i);
      chg_en_n_i <= 1'b1;
      apb(1'b1, OFF_CTRL, 32'h09);
      apb(1'b1, OFF_FAST_CHARGE_CURRENT, 32'h11);
    end
    $display("Test start conditions done");
    for (k = 0; k < 3; k++) begin
      @(posedge mclk_i);
      therm_fault_i <= 1'b0;
      {bat_below_2v2_i, bat_below_3v_i} <= (k == 0) ? 2'h3 : (k == 1) ? 2'h1 : 2'h0;
      restart();
      chk({30'h0, chg_current_sel_o}, k + 1);
      ph_chk((k == 2) ? PH_FAST : PH_PRE, 1'b0);
      chb(stat_o, 1'b0);
    end
    $display("Test phases done");
    @(posedge mclk_i);
    {iin_over_i, thermal_reg_i, bat_above_rechg_i} <= 3'h7;
    p0 = pulses;
    term(10);
    ph_chk(PH_FAST, 1'b0);
    @(posedge mclk_i);
    iin_over_i <= 1'b0;
    wn(8);
    ph_chk(PH_FAST, 1'b0);
    @(posedge mclk_i);
    thermal_reg_i <= 1'b0;
    wn(30);
    ph_chk(PH_DONE, 1'b0);
    chb(stat_o, 1'b1);
    chb(bat_switch_on_o, 1'b0);
    chk(pulses, p0 + 1);
    @(posedge mclk_i);
    fast_charge_current_below_term_i <= 1'b0;
    bat_above_rechg_i <= 1'b0;
    wn(10);
    ph_chk(PH_FAST, 1'b0);
    @(posedge mclk_i);
    bat_above_rechg_i <= 1'b1;
    term(30);
    ph_chk(PH_DONE, 1'b0);
    @(posedge mclk_i);
    fast_charge_current_below_term_i <= 1'b0;
    apb(1'b1, OFF_CTRL, 32'h08);
    apb(1'b1, OFF_CTRL, 32'h09);
    wn(8);
    ph_chk(PH_FAST, 1'b0);
    term(30);
    @(posedge mclk_i);
    fast_charge_current_below_term_i <= 1'b0;
    src_good_i <= 1'b0;
    wn(6);
    @(posedge mclk_i);
    src_good_i <= 1'b1;
    wn(8);
    ph_chk(PH_FAST, 1'b0);
    apb(1'b1, OFF_CTRL, 32'h01);
    term(12);
    ph_chk(PH_FAST, 1'b0);
    $display("Test termination done");
    for (k = 0; k < 2; k++) begin
      restart();
      apb(1'b1, OFF_CTRL, 32'h49);
      p0 = pulses;
      @(posedge mclk_i);
      safety_pause_i <= (k == 0);
      safety_half_i <= (k == 1);
      term(44);
      ph_chk(PH_DONE, 1'b1);
      chb(stat_o, 1'b1);
      if (k == 0) wn(100);
      if (k == 0) ph_chk(PH_DONE, 1'b1);
      @(posedge mclk_i);
      safety_pause_i <= 1'b0;
      wn(70);
      ph_chk(PH_DONE, 1'b0);
      chk(pulses, p0 + 3);
      safety_half_i <= 1'b0;
    end
    restart();
    apb(1'b1, OFF_CTRL, 32'hc9);
    term(40);
    ph_chk(PH_DONE, 1'b1);
    p0 = pulses;
    apb(1'b1, OFF_CTRL, 32'h09);
    ph_chk(PH_DONE, 1'b0);
    wn(20);
    chk(pulses, p0);
    $display("Test top-off done");
    restart();
    @(posedge mclk_i);
    safety_fault_i <= 1'b1;
    wn(6);
    hi = 0;
    repeat (40) begin
      @(negedge mclk_i);
      hi += stat_o;
    end
    chb(hi > 5 && hi < 35, 1'b1);
    apb(1'b0, OFF_STAT, 32'h0);
    chb(d[S_FAULT], 1'b1);
    chk(bad, 0);
    $display("Test status blink done");
    finish_test();
  end
endmodule // tb
